// ---- shared/port_regs_cfg.svh ----
// Offsets, field positions and reset values of the data port register set
`ifndef PORT_REGS_CFG_SVH
`define PORT_REGS_CFG_SVH

`define OFS_IRQ_FLAGS 8'h00
`define OFS_IRQ_ENABLE 8'h01
`define OFS_PORT_CONTROL 8'h02
`define BIT_TEST_FAIL 0
`define BIT_PORT_READY 1
`define BIT_INVERT_BANK 4
`define FLD_MODE_HI 3
`define FLD_MODE_LO 2
`define RST_REG 8'h00
`define PORT_COUNT 3
`define SYNC_STAGES 2

`endif

// ---- shared/port_regs_pkg.sv ----
// Types shared by the data port register set
package port_regs_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PRBS = 2'b01,
        MODE_STATIC0 = 2'b10,
        MODE_STATIC1 = 2'b11
    } data_mode_t;
endpackage : port_regs_pkg

// ---- hdl/port_reg_set.sv ----
// One data port's register set: flags, masks, port control
`timescale 1ns/1ps
`default_nettype none
`include "port_regs_cfg.svh"
module port_reg_set
    import port_regs_pkg::*;
#(
    parameter bit IS_SINK = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register access, synchronous to sys_clk
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Events and resets
    input wire logic sync_loss,
    input wire logic int_reset,
    input wire logic frame_end,
    input wire logic ready_evt,
    input wire logic test_err,
    input wire logic bank_sel,
    // Results
    output logic irq_d,
    output logic bank_eff_d,
    output data_mode_t mode
);
    logic [1:0] flags_q, flags_d, mask_q, mask_d;
    logic inv_q, inv_d, inv_pend_q, inv_pend_d, inv_new_q, inv_new_d;
    logic [1:0] mode_q, mode_d;

    always_comb begin
        flags_d = flags_q;
        mask_d = mask_q;
        inv_d = inv_q;
        inv_pend_d = inv_pend_q;
        inv_new_d = inv_new_q;
        mode_d = mode_q;
        if (wr_en && addr == `OFS_IRQ_FLAGS) begin
            flags_d = flags_q & ~wdata[1:0];
        end
        if (wr_en && addr == `OFS_IRQ_ENABLE) begin
            mask_d = wdata[1:0];
        end
        if (wr_en && addr == `OFS_PORT_CONTROL) begin
            mode_d = wdata[`FLD_MODE_HI:`FLD_MODE_LO];
            inv_new_d = wdata[`BIT_INVERT_BANK];
            inv_pend_d = 1'b1;
        end
        // Set wins over a same-cycle clear
        if (ready_evt) begin
            flags_d[`BIT_PORT_READY] = 1'b1;
        end
        if (IS_SINK && test_err && mode_q != MODE_NORMAL) begin
            flags_d[`BIT_TEST_FAIL] = 1'b1;
        end
        if (!IS_SINK) begin
            flags_d[`BIT_TEST_FAIL] = 1'b0;
        end
        if (frame_end && inv_pend_q) begin
            inv_d = inv_new_q;
            inv_pend_d = 1'b0;
        end
        // Flags survive sync loss; masks and inversion do not
        if (sync_loss || int_reset) begin
            mask_d = 2'b00;
            inv_d = 1'b0;
            inv_pend_d = 1'b0;
            inv_new_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= 2'b00;
            mask_q <= 2'b00;
            inv_q <= 1'b0;
            inv_pend_q <= 1'b0;
            inv_new_q <= 1'b0;
            mode_q <= 2'b00;
        end else begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            inv_q <= inv_d;
            inv_pend_q <= inv_pend_d;
            inv_new_q <= inv_new_d;
            mode_q <= mode_d;
        end
    end

    always_comb begin
        case (addr)
            `OFS_IRQ_FLAGS: rdata = {6'h00, flags_q};
            `OFS_IRQ_ENABLE: rdata = {6'h00, mask_q};
            `OFS_PORT_CONTROL: rdata = {3'h0, inv_q, mode_q, 2'h0};
            default: rdata = 8'h00;
        endcase
    end

    assign irq_d = |(flags_q & mask_q);
    assign bank_eff_d = bank_sel ^ inv_q;
    assign mode = data_mode_t'(mode_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ctrl_write;
        wr_en && addr == `OFS_PORT_CONTROL && !sync_loss && !int_reset && !frame_end;
    endsequence
    sequence s_frame_close;
        frame_end && inv_pend_q && !sync_loss && !int_reset;
    endsequence
    property p_flag_hold;
        @(posedge sys_clk) disable iff (!resetn)
            !(wr_en && addr == `OFS_IRQ_FLAGS) |=> (flags_q & $past(flags_q)) == $past(flags_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear");
    property p_mask_clear;
        @(posedge sys_clk) disable iff (!resetn)
            sync_loss || int_reset |=> mask_q == 2'b00;
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("mask kept over reset");
    property p_inv_defer;
        @(posedge sys_clk) disable iff (!resetn)
            s_ctrl_write |=> $stable(inv_q) && inv_pend_q;
    endproperty
    a_inv_defer: assert property (p_inv_defer) else $error("invert applied before frame end");
    property p_inv_apply;
        @(posedge sys_clk) disable iff (!resetn)
            s_frame_close |=> inv_q == $past(inv_new_q);
    endproperty
    a_inv_apply: assert property (p_inv_apply) else $error("invert not applied at frame end");
    property p_inv_clear;
        @(posedge sys_clk) disable iff (!resetn)
            sync_loss |=> !inv_q;
    endproperty
    a_inv_clear: assert property (p_inv_clear) else $error("invert kept over sync loss");
endmodule : port_reg_set
`default_nettype wire

// ---- hdl/data_port_regs.sv ----
// Top: register sets for data ports 1 to 3 with pin synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "port_regs_cfg.svh"
// Behaviour
// - One register set per data port, ports one to three.
// - Port-ready flag bit 1 sets when port becomes ready; resets zero.
// - Port-ready interrupts only when its mask bit is one.
// - Port-ready clears only on write-one; sync loss keeps it.
// - Sink ports 2,3 set test-fail bit 0 on mismatch in test modes.
// - Source port 1 never sets test-fail.
// - Test-fail clears only on write-one; sync loss keeps it.
// - Mask bit 1 enables port-ready, bit 0 enables test-fail.
// - Mask bits clear on internal reset and on sync loss.
// - Invert-bank bit 4 affects only this port's banked registers.
// - Invert zero uses control-word bank; one uses the opposite bank.
// - New invert value applies at the next frame end; one written at a frame end while another is pending is lost.
// - Invert bit clears on sync loss reset.
// - Mode bits 3:2: normal, PRBS, static zero, static one.
module data_port_regs
    import port_regs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register command, one-cycle write strobe
    input wire logic wr_en,
    input wire logic [1:0] port_sel,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Link side, asynchronous levels
    input wire logic frame_end_pin,
    input wire logic sync_loss_pin,
    input wire logic bank_sel_pin,
    // Internal events, sys_clk domain
    input wire logic int_reset,
    input wire logic [2:0] ready_evt,
    input wire logic [2:0] test_err,
    // Results per port
    output logic [2:0] irq,
    output logic [2:0] bank_eff,
    output logic [5:0] mode_flat
);
    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    // Shared by the write strobes and the checks
    function automatic logic port_hit(input logic [1:0] sel, input int idx);
        return sel == 2'(idx + 1);
    endfunction : port_hit

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Two stages each: the link levels have no timing relation to sys_clk
    logic [2:0] s1_q, s2_q, s1_d, s2_d;
    logic fe_last_q, fe_last_d;
    always_comb begin
        s1_d = {frame_end_pin, sync_loss_pin, bank_sel_pin};
        s2_d = s1_q;
        fe_last_d = s2_q[2];
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            fe_last_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            fe_last_q <= fe_last_d;
        end
    end
    // Rising edge of the frame end level marks the frame boundary
    logic frame_end;
    assign frame_end = s2_q[2] & ~fe_last_q;

    // ------------------------------------------------------------
    // Port register sets
    // ------------------------------------------------------------
    logic [7:0] rd [0:2];
    logic [2:0] irq_d, bank_d;
    data_mode_t md [0:2];
    genvar g;
    generate
        for (g = 0; g < `PORT_COUNT; g++) begin : g_port
            port_reg_set #(.IS_SINK(g != 0)) u_set (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .wr_en(wr_en && port_hit(port_sel, g)),
                .addr(addr),
                .wdata(wdata),
                .rdata(rd[g]),
                .sync_loss(s2_q[1]),
                .int_reset(int_reset),
                .frame_end(frame_end),
                .ready_evt(ready_evt[g]),
                .test_err(test_err[g]),
                .bank_sel(s2_q[0]),
                .irq_d(irq_d[g]),
                .bank_eff_d(bank_d[g]),
                .mode(md[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Registered outputs cost a cycle but never glitch
    logic [7:0] rdata_d;
    always_comb begin
        case (port_sel)
            2'h1: rdata_d = rd[0];
            2'h2: rdata_d = rd[1];
            2'h3: rdata_d = rd[2];
            default: rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
            irq <= 3'h0;
            bank_eff <= 3'h0;
            mode_flat <= 6'h00;
        end else begin
            rdata <= rdata_d;
            irq <= irq_d;
            bank_eff <= bank_d;
            mode_flat <= {md[2], md[1], md[0]};
        end
    end

    // ------------------------------------------------------------
    // Global checks
    // ------------------------------------------------------------
    property p_src_no_fail;
        @(posedge sys_clk) disable iff (!resetn)
            addr == `OFS_IRQ_FLAGS |-> rd[0][`BIT_TEST_FAIL] == 1'b0;
    endproperty
    a_src_no_fail: assert property (p_src_no_fail) else $error("port 1 test flag set");

    property p_rdata_none;
        @(posedge sys_clk) disable iff (!resetn)
            port_sel == 2'h0 |=> rdata == 8'h00;
    endproperty
    a_rdata_none: assert property (p_rdata_none) else $error("read data without a port");

    property p_frame_single;
        @(posedge sys_clk) disable iff (!resetn)
            frame_end |=> !frame_end;
    endproperty
    a_frame_single: assert property (p_frame_single) else $error("frame end longer than a cycle");

    // ------------------------------------------------------------
    // Per-port checks
    // ------------------------------------------------------------
    // Flags are seen through rd, so each antecedent of a check on rd names the read address
    generate
        for (g = 0; g < `PORT_COUNT; g++) begin : g_chk
            sequence s_ready_read;
                ready_evt[g] ##1 addr == `OFS_IRQ_FLAGS;
            endsequence
            property p_ready_read;
                @(posedge sys_clk) disable iff (!resetn)
                    s_ready_read |-> rd[g][`BIT_PORT_READY];
            endproperty
            a_ready_read: assert property (p_ready_read) else $error("ready flag not set");

            sequence s_fail_read;
                test_err[g] && md[g] != MODE_NORMAL ##1 addr == `OFS_IRQ_FLAGS;
            endsequence
            property p_fail_read;
                @(posedge sys_clk) disable iff (!resetn)
                    s_fail_read |-> rd[g][`BIT_TEST_FAIL] == (g != 0);
            endproperty
            a_fail_read: assert property (p_fail_read) else $error("test flag wrong after error");

            sequence s_ctrl_write;
                wr_en && port_hit(port_sel, g) && addr == `OFS_PORT_CONTROL;
            endsequence
            sequence s_ctrl_read;
                s_ctrl_write ##1 addr == `OFS_PORT_CONTROL;
            endsequence
            property p_mode_read;
                @(posedge sys_clk) disable iff (!resetn)
                    s_ctrl_read |-> rd[g][`FLD_MODE_HI:`FLD_MODE_LO] == $past(wdata[`FLD_MODE_HI:`FLD_MODE_LO]);
            endproperty
            a_mode_read: assert property (p_mode_read) else $error("mode field not written");

            property p_mode_out;
                @(posedge sys_clk) disable iff (!resetn)
                    s_ctrl_write |=> ##1 mode_flat[2*g +: 2] == $past(wdata[`FLD_MODE_HI:`FLD_MODE_LO], 2);
            endproperty
            a_mode_out: assert property (p_mode_out) else $error("mode output wrong");

            property p_bank_sync;
                @(posedge sys_clk) disable iff (!resetn)
                    s2_q[1] |=> ##1 bank_eff[g] == $past(s2_q[0]);
            endproperty
            a_bank_sync: assert property (p_bank_sync) else $error("bank still inverted after sync loss");

            property p_irq_clear;
                @(posedge sys_clk) disable iff (!resetn)
                    s2_q[1] || int_reset |=> ##1 !irq[g];
            endproperty
            a_irq_clear: assert property (p_irq_clear) else $error("interrupt kept over reset");

            sequence s_sync_idle;
                s2_q[1] && !wr_en && !ready_evt[g] && !test_err[g] && addr == `OFS_IRQ_FLAGS ##1 addr == `OFS_IRQ_FLAGS;
            endsequence
            property p_sync_flags;
                @(posedge sys_clk) disable iff (!resetn)
                    s_sync_idle |-> rd[g][1:0] == $past(rd[g][1:0]);
            endproperty
            a_sync_flags: assert property (p_sync_flags) else $error("flags changed on sync loss");
        end
    endgenerate
endmodule : data_port_regs
`default_nettype wire

// ---- testbench/link_mgr_model.sv ----
// Manager-side link model: frame edges, sync loss, bank select
`timescale 1ns/1ps
`default_nettype none
module link_mgr_model (
    // Link levels toward the device
    output var logic frame_end_pin,
    output var logic sync_loss_pin,
    output var logic bank_sel_pin
);
    initial begin
        frame_end_pin = 1'b0;
        sync_loss_pin = 1'b0;
        bank_sel_pin = 1'b0;
    end
    // One 80 ns link period, rising edge closes the frame
    task frame;
        #40 frame_end_pin = 1'b1;
        #40 frame_end_pin = 1'b0;
    endtask : frame
    task lose;
        sync_loss_pin = 1'b1;
        #80 sync_loss_pin = 1'b0;
    endtask : lose
    task set_bank(input logic b);
        bank_sel_pin = b;
    endtask : set_bank
endmodule : link_mgr_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the data port register sets
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic sys_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, int_reset = 1'b0;
    logic [1:0] port_sel = 2'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0] ready_evt = 3'h0, test_err = 3'h0, irq, bank_eff;
    logic [5:0] mode_flat;
    wire frame_end_pin, sync_loss_pin, bank_sel_pin;
    int num_errors = 0, comparisons = 0, seed = 10;
    // Reference state, index 0 is the unselected port
    logic [7:0] fl [4], mk [4], ct [4];
    logic bk [4];
    link_mgr_model u_link (.frame_end_pin(frame_end_pin), .sync_loss_pin(sync_loss_pin),
        .bank_sel_pin(bank_sel_pin));
    data_port_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .wr_en(wr_en), .port_sel(port_sel),
        .addr(addr), .wdata(wdata), .rdata(rdata), .frame_end_pin(frame_end_pin),
        .sync_loss_pin(sync_loss_pin), .bank_sel_pin(bank_sel_pin), .int_reset(int_reset),
        .ready_evt(ready_evt), .test_err(test_err), .irq(irq), .bank_eff(bank_eff), .mode_flat(mode_flat));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task wr(input int p, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        port_sel = p[1:0]; addr = a; wdata = d; wr_en = 1'b1;
        @(negedge sys_clk);
        wr_en = 1'b0;
        if (p != 0 && a == 8'h00) fl[p] = fl[p] & ~d;
        if (p != 0 && a == 8'h01) mk[p] = d & 8'h03;
        if (p != 0 && a == 8'h02) ct[p] = d & 8'h1C;
        repeat (3) @(negedge sys_clk);
    endtask : wr
    task chk_all;
        logic [7:0] e;
        for (int p = 0; p < 4; p++) begin
            for (int a = 0; a < 4; a++) begin
                @(negedge sys_clk);
                port_sel = p[1:0]; addr = a[7:0];
                repeat (3) @(negedge sys_clk);
                // Invert reads back only once applied at a frame end
                e = (p == 0 || a == 3) ? 8'h00 : (a == 0) ? fl[p] : (a == 1) ? mk[p] :
                    {3'b000, bk[p], ct[p][3:2], 2'b00};
                `CHK("rdata", e, rdata)
            end
        end
        for (int i = 0; i < 3; i++) begin
            `CHK("irq", |(fl[i+1] & mk[i+1] & 8'h03), irq[i])
            `CHK("bank_eff", bank_sel_pin ^ bk[i+1], bank_eff[i])
            `CHK("mode", ct[i+1][3:2], mode_flat[2*i +: 2])
        end
    endtask : chk_all
    task events(input logic [2:0] rdy, input logic [2:0] err);
        @(negedge sys_clk);
        ready_evt = rdy; test_err = err;
        addr = 8'h00;
        @(negedge sys_clk);
        ready_evt = 3'h0; test_err = 3'h0;
        for (int p = 1; p < 4; p++) begin
            if (rdy[p-1]) fl[p][1] = 1'b1;
            if (err[p-1] && p > 1 && ct[p][3:2] != 2'b00) fl[p][0] = 1'b1;
        end
    endtask : events
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        for (int p = 0; p < 4; p++) begin
            fl[p] = 8'h00; mk[p] = 8'h00; ct[p] = 8'h00; bk[p] = 1'b0;
        end
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        chk_all();
        $display("reset values done");
        for (int p = 1; p < 4; p++) wr(p, 8'h01, 8'($random(seed)));
        wr(1, 8'h01, 8'hFE);
        wr(2, 8'h02, 8'h04);
        wr(1, 8'h02, 8'h04);
        events(3'b111, 3'b111);
        chk_all();
        $display("events and masks done");
        for (int m = 0; m < 4; m++) begin
            wr(1, 8'h02, m[7:0] << 2);
            wr(3, 8'h02, 8'((3 - m) << 2));
            events(3'b000, 3'b111);
            chk_all();
        end
        $display("modes done");
        u_link.set_bank(1'b1);
        wr(2, 8'h02, 8'h10);
        chk_all();
        u_link.frame();
        repeat (6) @(negedge sys_clk);
        for (int p = 1; p < 4; p++) bk[p] = ct[p][4];
        chk_all();
        @(negedge sys_clk);
        addr = 8'h00;
        u_link.lose();
        repeat (6) @(negedge sys_clk);
        for (int p = 1; p < 4; p++) begin
            mk[p] = 8'h00; ct[p][4] = 1'b0; bk[p] = 1'b0;
        end
        chk_all();
        $display("invert and sync loss done");
        for (int p = 1; p < 4; p++) wr(p, 8'h01, 8'h03);
        @(negedge sys_clk);
        int_reset = 1'b1;
        @(negedge sys_clk);
        int_reset = 1'b0;
        for (int p = 1; p < 4; p++) mk[p] = 8'h00;
        repeat (3) @(negedge sys_clk);
        chk_all();
        wr(2, 8'h00, 8'h01);
        wr(3, 8'h00, 8'h02);
        wr(1, 8'h05, 8'hFF);
        chk_all();
        $display("clears done");
        @(negedge sys_clk);
        port_sel = 2'h2;
        addr = 8'h00;
        wdata = 8'h02;
        wr_en = 1'b1;
        ready_evt = 3'b010;
        @(negedge sys_clk);
        wr_en = 1'b0;
        ready_evt = 3'h0;
        fl[2] = fl[2] & ~8'h02;
        fl[2][1] = 1'b1;
        chk_all();
        $display("set over clear done");
        wrap_up();
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
